// ### core/dac_serial_load.v
// serial input and load control for a four channel converter
// Notes for users
// - pins pass two flip-flops, so each shift clock half period must last three mclk cycles.
// - a word is acted on two or three mclk cycles after its 24th falling edge is seen.
// - the load pin is edge detected behind the same two flip-flops, so its high and low
//   times must each last three mclk cycles as well.
// - the level select pin is read live and picks both the reset level and the coding.
// - the channel outputs are offset binary codes in both coding modes.
// - the word queue drains one word per cycle, so the overflow flag only rises if the
//   drain is ever stalled; a word met by a full queue is lost.
// - a word that meets its own load edge reaches the outputs with that edge.
`timescale 1ns/1ns
`default_nettype none
`include "dac_serial_map.vh"
module dac_serial_load #(
	parameter FIFO_DEPTH = `FIFO_DEPTH
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// serial pins
	input wire frame_sel_n,
	input wire shift_clk,
	input wire data_in,
	// control pins
	input wire if_enable_n,
	input wire reset_level_select,
	input wire load_outputs,
	// channel codes and status
	output reg [`CODE_BITS-1:0] chan_a,
	output reg [`CODE_BITS-1:0] chan_b,
	output reg [`CODE_BITS-1:0] chan_c,
	output reg [`CODE_BITS-1:0] chan_d,
	output wire word_overflow
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [4:0] sync1_reg;
	reg [4:0] sync2_reg;
	// edge detector history
	reg clk_last_reg;
	reg load_last_reg;
	// frame assembly
	reg [`FRAME_BITS-1:0] shift_reg;
	reg [`FRAME_CNT_W-1:0] bit_cnt_reg;
	reg frame_ok_reg;
	wire [`CHAN_COUNT*`CODE_BITS-1:0] out_flat;
	// synchronised pin levels
	wire fs_n;
	wire sck;
	wire din;
	wire en_n;
	wire ld;
	// decoded events
	wire fall;
	wire ld_rise;
	wire active;
	wire last_bit;
	wire [`FRAME_BITS-1:0] word;
	// queue and word fields
	wire [`FRAME_BITS-1:0] head;
	wire head_valid;
	wire in_ready;
	wire [1:0] addr;
	wire [`CODE_BITS-1:0] code_raw;
	wire [`CODE_BITS-1:0] code_bin;
	wire [`CODE_BITS-1:0] rst_code;

	// first stage feeds only the second stage
	// reset values are all high so no pin that idles high looks like a falling edge as reset ends
	always @(posedge mclk) begin
		if (!rst_n) begin
			sync1_reg <= 5'h1f;
			sync2_reg <= 5'h1f;
		end else begin
			sync1_reg <= {load_outputs, if_enable_n, data_in, shift_clk, frame_sel_n};
			sync2_reg <= sync1_reg;
		end
	end
	// named taps of the second stage
	assign fs_n = sync2_reg[0];
	assign sck = sync2_reg[1];
	assign din = sync2_reg[2];
	assign en_n = sync2_reg[3];
	assign ld = sync2_reg[4];

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// history resets high: the idle shift clock is high, so no false fall follows reset,
	// and a load pin that sits low after reset only ever shows a falling edge
	always @(posedge mclk) begin
		if (!rst_n) begin
			clk_last_reg <= 1'b1;
			load_last_reg <= 1'b1;
		end else begin
			clk_last_reg <= sck;
			load_last_reg <= ld;
		end
	end
	assign fall = clk_last_reg & ~sck;
	assign ld_rise = ~load_last_reg & ld;
	assign active = ~fs_n & ~en_n;
	assign last_bit = (bit_cnt_reg == `FRAME_LAST);
	assign word = {shift_reg[`FRAME_BITS-2:0], din};

	// ----------------------------------------
	// shift register and frame counter
	// ----------------------------------------
	// a dropped frame select clears the count, so a short frame never lands
	always @(posedge mclk) begin
		if (!rst_n) begin
			shift_reg <= {`FRAME_BITS{1'b0}};
			bit_cnt_reg <= {`FRAME_CNT_W{1'b0}};
			frame_ok_reg <= 1'b1;
		end else if (!active) begin
			// leaving the frame or losing the enable throws the count away
			bit_cnt_reg <= {`FRAME_CNT_W{1'b0}};
			frame_ok_reg <= 1'b1;
		end else if (fall && frame_ok_reg) begin
			// one bit per falling edge, msb first
			shift_reg <= word;
			if (last_bit) begin
				bit_cnt_reg <= {`FRAME_CNT_W{1'b0}};
				frame_ok_reg <= 1'b0; // extra edges ignored until next frame
			end else
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
		end
	end

	// finished words queue here; a full queue drops the word and flags it
	// the channel side pops every cycle, so the queue stays nearly empty; it is kept so
	// a stalled consumer can be added later without touching the frame logic
	word_fifo #(
		.WIDTH(`FRAME_BITS),
		.DEPTH(FIFO_DEPTH),
		.PTR_W(`FIFO_PTR_W)
	) word_fifo_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_data(word),
		.in_valid(active & fall & frame_ok_reg & last_bit),
		.in_ready(in_ready),
		.out_data(head),
		.out_valid(head_valid),
		.out_ready(1'b1)
	);
	assign word_overflow = ~in_ready;

	// ----------------------------------------
	// coding and channel registers
	// ----------------------------------------
	// the queue head is consumed in the cycle it appears, so head_valid is a one cycle strobe
	assign addr = head[`FIELD_ADDR_HI:`FIELD_ADDR_LO];
	assign code_raw = head[`FIELD_CODE_HI:`FIELD_CODE_LO];
	// two's complement flips the top bit to reach offset binary
	assign code_bin = reset_level_select ? {~code_raw[`CODE_BITS-1], code_raw[`CODE_BITS-2:0]}
		: code_raw;
	// the select pin is read live, so a change mid run recodes later words only
	assign rst_code = reset_level_select ? `MID_SCALE_BIN : `ZERO_SCALE_BIN;

	genvar ch;
	generate
		for (ch = 0; ch < `CHAN_COUNT; ch = ch + 1) begin : g_chan
			reg [`CODE_BITS-1:0] pend_reg;
			reg [`CODE_BITS-1:0] out_reg;
			wire hit;
			// the head word addresses this channel
			assign hit = head_valid && (addr == ch);
			// reset parks both stages at the chosen level, so an unwritten channel keeps
			// it across later load edges instead of falling to code zero
			always @(posedge mclk) begin
				if (!rst_n) begin
					pend_reg <= rst_code;
					out_reg <= rst_code;
				end else begin
					if (hit)
						pend_reg <= code_bin;
					// a word landing with the load edge is taken straight through
					if (ld_rise)
						out_reg <= hit ? code_bin : pend_reg;
				end
			end
			assign out_flat[ch*`CODE_BITS +: `CODE_BITS] = out_reg;
		end
	endgenerate

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	// outputs hold the reset level while reset is low, then the loaded values; the extra
	// stage costs one cycle of load latency but keeps every output a plain flip-flop
	always @(posedge mclk) begin
		if (!rst_n) begin
			chan_a <= rst_code;
			chan_b <= rst_code;
			chan_c <= rst_code;
			chan_d <= rst_code;
		end else begin
			chan_a <= out_flat[`CODE_BITS-1:0];
			chan_b <= out_flat[2*`CODE_BITS-1:`CODE_BITS];
			chan_c <= out_flat[3*`CODE_BITS-1:2*`CODE_BITS];
			chan_d <= out_flat[4*`CODE_BITS-1:3*`CODE_BITS];
		end
	end
endmodule // dac_serial_load
`default_nettype wire

// ### inc/dac_serial_map.vh
// constants for the quad converter serial load control
`ifndef DAC_SERIAL_MAP_VH
`define DAC_SERIAL_MAP_VH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define FRAME_BITS 24
`define FRAME_CNT_W 5
`define FRAME_LAST 5'd23
`define CHAN_COUNT 4
`define CODE_BITS 14
// ----------------------------------------
// word fields (address in bits 17:16, code left justified in 15:2)
// ----------------------------------------
`define FIELD_ADDR_HI 17
`define FIELD_ADDR_LO 16
`define FIELD_CODE_HI 15
`define FIELD_CODE_LO 2
// ----------------------------------------
// reset values and queue size
// ----------------------------------------
`define ZERO_SCALE_BIN 14'h0000
`define MID_SCALE_BIN 14'h2000
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4
`endif

// ### core/word_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter PTR_W = 4
) (
	input wire mclk,
	input wire rst_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_reg;
	reg [PTR_W-1:0] rd_ptr_reg;
	reg [PTR_W:0] count_reg;
	wire push;
	wire pop;

	// ----------------------------------------
	// flags
	// ----------------------------------------
	assign in_ready = (count_reg != DEPTH[PTR_W:0]);
	assign out_valid = (count_reg != {(PTR_W+1){1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage and pointers
	always @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr_reg <= {PTR_W{1'b0}};
			rd_ptr_reg <= {PTR_W{1'b0}};
			count_reg <= {(PTR_W+1){1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr_reg] <= in_data;
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	// head word; data output is an unregistered read of the storage array
	always @* begin
		out_data = mem[rd_ptr_reg];
	end
endmodule // word_fifo
`default_nettype wire

// ### sim/dac_host_model.sv
// host side serial controller model
`timescale 1ns/1ns
`default_nettype none
module dac_host_model (
	output logic frame_sel_n,
	output logic shift_clk,
	output logic data_in
);
	initial frame_sel_n = 1'b1;
	initial shift_clk = 1'b1;
	initial data_in = 1'b0;
	// 125 ns shift clock that stands still between frames
	task automatic send(input logic [23:0] word, input int nbits);
		frame_sel_n = 1'b0;
		for (int i = 23; i > 23 - nbits; i--) begin
			data_in = word[i];
			#31 shift_clk = 1'b0;
			#62 shift_clk = 1'b1;
			#32;
		end
		frame_sel_n = 1'b1;
		// released data line must not look like valid bits
		data_in = ~data_in;
		#100;
	endtask
endmodule // dac_host_model
`default_nettype wire

// ### sim/dac_serial_load_sva.sv
// assertion checker for the serial load block
`timescale 1ns/1ns
`default_nettype none
`include "dac_serial_map.vh"
module dac_serial_load_sva (
	input wire mclk,
	input wire rst_n,
	input wire load_outputs,
	input wire reset_level_select,
	input wire [`CODE_BITS-1:0] chan_a,
	input wire [`CODE_BITS-1:0] chan_b,
	input wire [`CODE_BITS-1:0] chan_c,
	input wire [`CODE_BITS-1:0] chan_d,
	input wire word_overflow
);
	logic [3:0] quiet_reg;
	wire [4*`CODE_BITS-1:0] all_chan = {chan_a, chan_b, chan_c, chan_d};
	wire [`CODE_BITS-1:0] lvl = reset_level_select ? `MID_SCALE_BIN : `ZERO_SCALE_BIN;
	// cycles since reset or load edge, saturating; outputs only move near one
	always @(posedge mclk) begin
		if (!rst_n || $rose(load_outputs))
			quiet_reg <= 4'h0;
		else if (quiet_reg != 4'hf)
			quiet_reg <= quiet_reg + 4'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_RST_HELD: assert property ($rose(rst_n) |-> $past(all_chan) == {4{$past(lvl)}})
		else $error("outputs not at reset level in reset");
	AST_RST_LVL_AB: assert property ($rose(rst_n) |-> ##[1:3] chan_a == lvl && chan_b == lvl)
		else $error("a or b not at reset level");
	AST_RST_LVL_CD: assert property ($rose(rst_n) |-> ##[1:3] chan_c == lvl && chan_d == lvl)
		else $error("c or d not at reset level");
	AST_OVF_CLEAR: assert property ($rose(rst_n) |-> !word_overflow [*3])
		else $error("queue full after reset");
	AST_LOAD_ONLY: assert property (quiet_reg > 4'd8 |-> $stable(all_chan))
		else $error("outputs moved without load edge");
	AST_LEVEL_NO_LOAD: assert property (load_outputs [*8] ##1 load_outputs |-> $stable(all_chan))
		else $error("high load level moved outputs");
	AST_FALL_NO_LOAD: assert property ($fell(load_outputs) && quiet_reg > 4'd6 |=> $stable(all_chan) [*4])
		else $error("falling load moved outputs");
	AST_IDLE_HOLD: assert property (!load_outputs [*8] |-> $stable(all_chan))
		else $error("outputs moved with load low");
	cover property ($rose(load_outputs));
	cover property ($rose(rst_n) && reset_level_select);
	cover property ($changed(chan_d));
endmodule // dac_serial_load_sva
bind dac_serial_load dac_serial_load_sva dac_serial_load_sva_i (.mclk, .rst_n, .load_outputs,
	.reset_level_select, .chan_a, .chan_b, .chan_c, .chan_d, .word_overflow);
`default_nettype wire

// ### sim/quad_dac_serial_load_control_tb.sv
// self-checking bench for the serial load block
`timescale 1ns/1ns
`default_nettype none
`include "dac_serial_map.vh"
module quad_dac_serial_load_control_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic if_enable_n = 1'b0;
	logic reset_level_select = 1'b0;
	logic load_outputs = 1'b0;
	wire frame_sel_n, shift_clk, data_in, word_overflow;
	wire [`CODE_BITS-1:0] chan_a, chan_b, chan_c, chan_d;
	logic [`CODE_BITS-1:0] want [4];
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	always #2 mclk = ~mclk;
	dac_host_model dac_host_model_i (.frame_sel_n, .shift_clk, .data_in);
	dac_serial_load dac_serial_load_i (.mclk, .rst_n, .frame_sel_n, .shift_clk, .data_in,
		.if_enable_n, .reset_level_select, .load_outputs, .chan_a, .chan_b, .chan_c, .chan_d,
		.word_overflow);
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// cut a hang short well past the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			end_sim;
		end
	end
	task automatic chk;
		@(negedge mclk);
		n_checks++;
		if (word_overflow !== 1'b0)
			$display("unexpected at %0t: word queue reported full", $time);
		if (word_overflow !== 1'b0)
			miscompares++;
		if ({chan_a, chan_b, chan_c, chan_d} !== {want[0], want[1], want[2], want[3]})
			$display("unexpected at %0t: outputs %h %h %h %h", $time, chan_a, chan_b, chan_c,
				chan_d);
		if ({chan_a, chan_b, chan_c, chan_d} !== {want[0], want[1], want[2], want[3]})
			miscompares++;
	endtask
	task automatic do_reset(input logic lvl);
		@(posedge mclk) rst_n <= 1'b0;
		reset_level_select <= lvl;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	task automatic put(input int ch, input logic [13:0] code, input int nbits);
		dac_host_model_i.send({6'h00, ch[1:0], code, 2'b00}, nbits);
	endtask
	// long pulse so level and falling edge are both exercised
	task automatic pulse_load;
		@(posedge mclk) load_outputs <= 1'b1;
		repeat (12) @(posedge mclk);
		load_outputs <= 1'b0;
		repeat (12) @(posedge mclk);
	endtask
	task automatic t_reset_levels;
		for (int l = 0; l < 2; l++) begin
			do_reset(l[0]);
			want = '{4{l ? `MID_SCALE_BIN : `ZERO_SCALE_BIN}};
			chk;
		end
		$display("test reset levels done");
	endtask
	task automatic t_twos;
		put(0, 14'h1fff, 24);
		put(3, 14'h0000, 24);
		chk;
		pulse_load;
		want[0] = 14'h3fff;
		want[3] = 14'h2000;
		chk;
		$display("test twos complement done");
	endtask
	task automatic t_write;
		do_reset(1'b0);
		want = '{4{`ZERO_SCALE_BIN}};
		put(0, 14'h0001, 24);
		put(1, 14'h2aaa, 24);
		put(2, 14'h1555, 24);
		put(3, 14'h3ffe, 24);
		chk;
		pulse_load;
		want = '{14'h0001, 14'h2aaa, 14'h1555, 14'h3ffe};
		chk;
		$display("test write done");
	endtask
	// a cut frame, a good word to channel 1, then a word sent with the port disabled
	task automatic t_refuse;
		put(0, 14'h0abc, 23);
		put(1, 14'h0123, 24);
		@(posedge mclk) if_enable_n <= 1'b1;
		put(2, 14'h0777, 24);
		@(posedge mclk) if_enable_n <= 1'b0;
		pulse_load;
		want[1] = 14'h0123;
		chk;
		$display("test refused frames done");
	endtask
	initial begin
		t_reset_levels;
		t_twos;
		t_write;
		t_refuse;
		end_sim;
	end
endmodule // quad_dac_serial_load_control_tb
`default_nettype wire
